// ==== tscc_pkg.sv ====
// package: constants, types and arithmetic of the cable channel coder
package tscc_pkg;

  // ====================================================================
  // packet framing
  localparam int PKT_LEN = 188;
  localparam int PAR_LEN = 16;
  localparam int CW_LEN = PKT_LEN + PAR_LEN;
  localparam int RS_PAD = 51;
  localparam int GROUP_LEN = 8;
  localparam logic [7:0] SYNC_BYTE = 8'h47;
  localparam logic [7:0] SYNC_INV = 8'hB8;

  // ====================================================================
  // energy dispersal
  localparam int PRBS_LEN = 15;
  localparam logic [14:0] PRBS_INIT = 15'h00A9;

  // ====================================================================
  // reed-solomon field
  localparam logic [7:0] FIELD_POLY = 8'h1D;
  localparam logic [7:0] RS_LAMBDA = 8'h02;

  // ====================================================================
  // interleaver and buffer
  localparam int ILV_I = 12;
  localparam int ILV_M = 17;
  localparam int BUF_DEPTH = 2;

  // ====================================================================
  // reset values
  localparam logic [7:0] POS_RST = 8'h00;
  localparam logic [2:0] GRP_RST = 3'h0;

  typedef enum logic {
    TSCC_PH_DATA = 1'b0,
    TSCC_PH_PARITY = 1'b1
  } tscc_phase_t;

  typedef struct packed {
    logic start;
    logic [7:0] data;
  } tscc_byte_t;

  // ====================================================================
  // galois field multiply
  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] acc;
    logic [7:0] sh;
    acc = 8'h00;
    sh = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        acc = acc ^ sh;
      end
      sh = sh[7] ? ({sh[6:0], 1'b0} ^ FIELD_POLY) : {sh[6:0], 1'b0};
    end
    return acc;
  endfunction

  // generator coefficients, index 16 is the monic term
  function automatic logic [16:0][7:0] rs_gen();
    logic [16:0][7:0] g;
    logic [7:0] r;
    g = '0;
    g[0] = 8'h01;
    r = 8'h01;
    for (int i = 0; i < PAR_LEN; i++) begin
      for (int k = PAR_LEN; k > 0; k--) begin
        g[k] = g[k-1] ^ gf_mul(g[k], r);
      end
      g[0] = gf_mul(g[0], r);
      r = gf_mul(r, RS_LAMBDA);
    end
    return g;
  endfunction

endpackage

// ==== tscc_stream_buf.sv ====
// small valid/ready buffer in the output byte path
`timescale 1ns/1ps
module tscc_stream_buf #(
  parameter int W = 9,
  parameter int D = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = (D > 1) ? $clog2(D) : 1;

  if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
    $error("buffer depth must be a power of two, at least 2");
  end

  logic [D-1:0][W-1:0] store;
  logic [D-1:0][W-1:0] next_store;
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] next_wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW-1:0] next_rd_idx;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  // ====================================================================
  // pointers and storage
  always_comb begin
    in_ready = (count != (AW + 1)'(D));
    out_valid = (count != '0);
    out_data = store[rd_idx];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_store = store;
    next_wr_idx = wr_idx;
    next_rd_idx = rd_idx;
    next_count = count;
    if (push) begin
      next_store[wr_idx] = in_data;
      next_wr_idx = wr_idx + 1'b1;
    end
    if (pop) begin
      next_rd_idx = rd_idx + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      store <= '0;
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
    end else begin
      store <= next_store;
      wr_idx <= next_wr_idx;
      rd_idx <= next_rd_idx;
      count <= next_count;
    end
  end

endmodule

// ==== ts_cable_channel_coder.sv ====
// transport stream cable channel coder: scrambler, rs(204,188), interleaver
`timescale 1ns/1ps
module ts_cable_channel_coder #(
  parameter int ILV_I = tscc_pkg::ILV_I,
  parameter int ILV_M = tscc_pkg::ILV_M
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic deint_mode,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  input wire logic in_start,
  output logic out_valid,
  input wire logic out_ready,
  output tscc_pkg::tscc_byte_t out_byte
);

  localparam int MEM_LEN = ILV_M * ILV_I * (ILV_I - 1) / 2;
  localparam int IDXW = $clog2(MEM_LEN);
  localparam int BRW = $clog2(ILV_I);
  localparam logic [16:0][7:0] RS_G = tscc_pkg::rs_gen();
  localparam int RS_FULL = tscc_pkg::RS_PAD + tscc_pkg::CW_LEN;

  // ====================================================================
  // elaboration checks
  if (ILV_I < 2 || ILV_M < 1 || ILV_M * (ILV_I - 1) > 255) begin : g_bad_ilv
    $error("interleaver branch depth must fit eight bits");
  end
  if (ILV_I * ILV_M != tscc_pkg::CW_LEN) begin : g_bad_frame
    $error("interleaver must span exactly one codeword");
  end
  if (RS_FULL != 2 ** $bits(tscc_pkg::FIELD_POLY) - 1) begin : g_bad_pad
    $error("padding and codeword must fill the full-length code");
  end
  if (tscc_pkg::GROUP_LEN != 2 ** $bits(tscc_pkg::GRP_RST)) begin : g_bad_group
    $error("group length must match the group counter");
  end
  if (tscc_pkg::PRBS_LEN != $bits(tscc_pkg::PRBS_INIT)) begin : g_bad_prbs
    $error("scrambler length must match its seed");
  end

  // ====================================================================
  // branch geometry
  function automatic logic [7:0] br_depth(input logic [BRW-1:0] j, input logic rev);
    int d;
    d = rev ? ILV_M * (ILV_I - 1 - int'(j)) : ILV_M * int'(j);
    return 8'(d);
  endfunction

  function automatic logic [IDXW-1:0] br_base(input logic [BRW-1:0] j, input logic rev);
    int s;
    s = 0;
    for (int k = 0; k < ILV_I; k++) begin
      if (k < int'(j)) begin
        s = s + int'(br_depth(BRW'(k), rev));
      end
    end
    return IDXW'(s);
  endfunction

  // eight generator steps, returns next state above the key byte
  function automatic logic [22:0] prbs_byte(input logic [14:0] st);
    logic [14:0] s;
    logic [7:0] key;
    logic fb;
    s = st;
    key = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      fb = s[13] ^ s[14];
      key[b] = fb;
      s = {s[13:0], fb};
    end
    return {s, key};
  endfunction

  // ====================================================================
  // coder state
  tscc_pkg::tscc_phase_t phase;
  tscc_pkg::tscc_phase_t next_phase;
  logic [7:0] pos;
  logic [7:0] next_pos;
  logic [2:0] grp;
  logic [2:0] next_grp;
  logic [14:0] prbs;
  logic [14:0] next_prbs;
  logic [15:0][7:0] par;
  logic [15:0][7:0] next_par;

  logic buf_ready;
  logic step;
  logic is_sync;
  logic [7:0] fb;
  logic [22:0] prbs_step;
  tscc_pkg::tscc_byte_t cw;

  // ====================================================================
  // scrambler, encoder and framing
  always_comb begin
    next_phase = phase;
    next_pos = pos;
    next_grp = grp;
    next_prbs = prbs;
    next_par = par;
    step = 1'b0;
    is_sync = 1'b0;
    fb = 8'h00;
    cw = '0;
    prbs_step = prbs_byte(prbs);
    // parity slots take no input byte
    in_ready = buf_ready && (deint_mode || phase == tscc_pkg::TSCC_PH_DATA);
    if (deint_mode) begin
      step = in_valid && buf_ready;
      cw.data = in_data;
      cw.start = in_start && (in_data == tscc_pkg::SYNC_BYTE || in_data == tscc_pkg::SYNC_INV);
    end else begin
      case (phase)
        tscc_pkg::TSCC_PH_DATA: begin
          step = in_valid && buf_ready;
          is_sync = in_start || pos == tscc_pkg::POS_RST;
          cw.start = is_sync;
          if (is_sync && grp == tscc_pkg::GRP_RST) begin
            cw.data = ~in_data;
          end else if (is_sync) begin
            cw.data = in_data;
          end else begin
            cw.data = in_data ^ prbs_step[7:0];
          end
          fb = cw.data ^ (is_sync ? 8'h00 : par[tscc_pkg::PAR_LEN-1]);
          if (step) begin
            for (int i = 0; i < tscc_pkg::PAR_LEN; i++) begin
              next_par[i] = ((i == 0 || is_sync) ? 8'h00 : par[i-1]) ^
                tscc_pkg::gf_mul(fb, RS_G[i]);
            end
            if (is_sync && grp == tscc_pkg::GRP_RST) begin
              next_prbs = tscc_pkg::PRBS_INIT;
            end else begin
              next_prbs = prbs_step[22:8];
            end
            if (is_sync) begin
              next_grp = grp + 3'h1;
            end
            next_pos = (is_sync ? tscc_pkg::POS_RST : pos) + 8'h01;
            if (next_pos == 8'(tscc_pkg::PKT_LEN)) begin
              next_phase = tscc_pkg::TSCC_PH_PARITY;
            end
          end
        end
        tscc_pkg::TSCC_PH_PARITY: begin
          step = buf_ready;
          cw.data = par[tscc_pkg::PAR_LEN-1];
          if (step) begin
            next_par = {par[tscc_pkg::PAR_LEN-2:0], 8'h00};
            // pos runs on through the parity slots
            next_pos = pos + 8'h01;
            if (pos == 8'(tscc_pkg::CW_LEN - 1)) begin
              next_pos = tscc_pkg::POS_RST;
              next_phase = tscc_pkg::TSCC_PH_DATA;
            end
          end
        end
        default: begin
          next_phase = tscc_pkg::TSCC_PH_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      phase <= tscc_pkg::TSCC_PH_DATA;
      pos <= tscc_pkg::POS_RST;
      grp <= tscc_pkg::GRP_RST;
      prbs <= tscc_pkg::PRBS_INIT;
      par <= '0;
    end else begin
      phase <= next_phase;
      pos <= next_pos;
      grp <= next_grp;
      prbs <= next_prbs;
      par <= next_par;
    end
  end

  // ====================================================================
  // convolutional interleaver / de-interleaver
  logic [MEM_LEN-1:0][7:0] mem;
  logic [MEM_LEN-1:0][7:0] next_mem;
  logic [ILV_I-1:0][7:0] ptr;
  logic [ILV_I-1:0][7:0] next_ptr;
  logic [BRW-1:0] comm;
  logic [BRW-1:0] next_comm;
  logic locked;
  logic next_locked;

  logic [BRW-1:0] br;
  logic [7:0] depth;
  logic [IDXW-1:0] idx;
  tscc_pkg::tscc_byte_t ilv;

  always_comb begin
    next_mem = mem;
    next_ptr = ptr;
    next_comm = comm;
    next_locked = locked;
    br = comm;
    ilv = '0;
    // once locked, later deint syncs ride the commutator
    if (cw.start && (!deint_mode || !locked)) begin
      br = '0;
    end
    // branch depth 17*j, reversed when de-interleaving
    depth = br_depth(br, deint_mode);
    idx = br_base(br, deint_mode) + IDXW'(ptr[br]);
    ilv.data = (depth == 8'h00) ? cw.data : mem[idx];
    // deint start only after lock, on branch zero
    if (deint_mode) begin
      ilv.start = locked && br == '0 &&
        (ilv.data == tscc_pkg::SYNC_BYTE || ilv.data == tscc_pkg::SYNC_INV);
    end else begin
      ilv.start = cw.start;
    end
    if (step) begin
      // fifo branch shift
      // the cell just read takes the new byte
      if (depth != 8'h00) begin
        next_mem[idx] = cw.data;
        next_ptr[br] = (ptr[br] == depth - 8'h01) ? 8'h00 : ptr[br] + 8'h01;
      end
      next_comm = (br == BRW'(ILV_I - 1)) ? '0 : br + 1'b1;
      if (deint_mode && cw.start) begin
        next_locked = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem <= '0;
      ptr <= '0;
      comm <= '0;
      locked <= 1'b0;
    end else begin
      mem <= next_mem;
      ptr <= next_ptr;
      comm <= next_comm;
      locked <= next_locked;
    end
  end

  // ====================================================================
  // output buffer
  tscc_stream_buf #(
    .W($bits(tscc_pkg::tscc_byte_t)),
    .D(tscc_pkg::BUF_DEPTH)
  ) u_out_buf (
    .clk(clk),
    .reset(reset),
    .in_valid(step),
    .in_ready(buf_ready),
    .in_data(ilv),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_byte)
  );

endmodule

// ==== tscc_monitor.sv ====
// port checker for the cable channel coder
`timescale 1ns/1ps
module tscc_monitor #(
  parameter int ILV_I = 12,
  parameter int ILV_M = 17
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic deint_mode,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [7:0] in_data,
  input wire logic in_start,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire tscc_pkg::tscc_byte_t out_byte
);
  logic tk;
  logic ot;
  logic [7:0] ep;
  logic [7:0] pos;
  logic [2:0] grp;
  int oc;
  logic seen;
  assign tk = in_valid && in_ready;
  assign ot = out_valid && out_ready;
  assign ep = in_start ? 8'h00 : pos;
  // ====================
  // packet position, group and output spacing
  always_ff @(posedge clk) begin
    if (reset) begin
      pos <= 8'h00;
      grp <= 3'h0;
      oc <= 0;
      seen <= 1'b0;
    end else begin
      if (tk) pos <= (ep == 8'hBB) ? 8'h00 : ep + 8'h01;
      if (tk && ep == 8'h00) grp <= grp + 3'h1;
      if (ot) oc <= out_byte.start ? 0 : oc + 1;
      if (ot && out_byte.start) seen <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_sync;
    out_valid && out_byte.start |-> out_byte.data inside {8'h47, 8'hB8};
  endproperty
  a_sync: assert property (p_sync) else $error("start on data");
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_byte);
  endproperty
  a_hold: assert property (p_hold) else $error("byte lost");
  property p_full;
    (in_valid && !out_ready) [*3] |-> !in_ready;
  endproperty
  a_full: assert property (p_full) else $error("full not refused");
  property p_lat;
    tk && !out_valid |=> out_valid;
  endproperty
  a_lat: assert property (p_lat) else $error("no output");
  property p_par;
    tk && ep == 8'hBB && !deint_mode |=> !in_ready [*8];
  endproperty
  a_par: assert property (p_par) else $error("no parity gap");
  property p_inv;
    tk && ep == 8'h00 && in_data == 8'h47 && grp == 3'h0 && !out_valid && !deint_mode
      |=> out_byte == 9'h1B8;
  endproperty
  a_inv: assert property (p_inv) else $error("sync not inverted");
  property p_plain;
    tk && ep == 8'h00 && in_data == 8'h47 && grp != 3'h0 && !out_valid && !deint_mode
      |=> out_byte == 9'h147;
  endproperty
  a_plain: assert property (p_plain) else $error("sync altered");
  property p_gap;
    ot && out_byte.start && seen && !deint_mode |-> oc == ILV_I * ILV_M - 1;
  endproperty
  a_gap: assert property (p_gap) else $error("sync spacing");
  property p_dready;
    deint_mode && !out_valid |-> in_ready;
  endproperty
  a_dready: assert property (p_dready) else $error("deint refused");
  c_inv: cover property (tk && ep == 8'h00 && grp == 3'h0);
  c_full: cover property (in_valid && !in_ready && !out_ready);
  c_deint: cover property (deint_mode && ot);
endmodule
bind ts_cable_channel_coder tscc_monitor #(.ILV_I(ILV_I), .ILV_M(ILV_M)) u_mon (
  .clk(clk), .reset(reset), .deint_mode(deint_mode), .in_valid(in_valid),
  .in_ready(in_ready), .in_data(in_data), .in_start(in_start), .out_valid(out_valid),
  .out_ready(out_ready), .out_byte(out_byte));

// ==== tscc_sink.sv ====
// far-side byte sink with stalls
`timescale 1ns/1ps
module tscc_sink (
  input wire logic clk,
  input wire logic reset,
  input wire logic stall,
  input wire logic out_valid,
  output logic out_ready,
  input wire tscc_pkg::tscc_byte_t out_byte
);
  tscc_pkg::tscc_byte_t mem [0:4095];
  int n;
  int cyc;
  initial out_ready = 1'b0;
  // one slow slot in five
  always @(negedge clk) begin
    cyc <= cyc + 1;
    out_ready <= !stall && (cyc % 5 != 3);
  end
  always @(posedge clk) begin
    if (reset) begin
      n <= 0;
    end else if (out_valid && out_ready) begin
      mem[n] <= out_byte;
      n <= n + 1;
    end
  end
endmodule

// ==== test_ts_cable_channel_coder.sv ====
// bench for the cable channel coder
`timescale 1ns/1ps
module test_ts_cable_channel_coder;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic deint_mode = 1'b0;
  logic in_valid = 1'b0;
  logic in_ready;
  logic [7:0] in_data = 8'h00;
  logic in_start = 1'b0;
  logic out_valid;
  logic out_ready;
  logic stall = 1'b0;
  tscc_pkg::tscc_byte_t out_byte;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  ts_cable_channel_coder u_dut (.clk(clk), .reset(reset), .deint_mode(deint_mode),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .in_start(in_start),
    .out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte));
  tscc_sink u_sink (.clk(clk), .reset(reset), .stall(stall), .out_valid(out_valid),
    .out_ready(out_ready), .out_byte(out_byte));
  always #12.5 clk = ~clk;
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task do_reset(input logic dm);
    @(negedge clk);
    reset = 1'b1;
    deint_mode = dm;
    repeat (2) @(negedge clk);
    reset = 1'b0;
  endtask
  task send(input logic [7:0] d, input logic st);
    @(negedge clk);
    in_valid = 1'b1;
    in_data = d;
    in_start = st;
    #1;
    while (in_ready !== 1'b1) begin
      @(negedge clk);
      #1;
    end
    @(posedge clk);
  endtask
  task idle;
    @(negedge clk);
    in_valid = 1'b0;
    in_start = 1'b0;
  endtask
  function logic [7:0] din(int p, int i);
    return (i == 0) ? 8'h47 : 8'(p * 3 + i * 5);
  endfunction
  function logic [7:0] xt(logic [7:0] x);
    return {x[6:0], 1'b0} ^ (x[7] ? 8'h1D : 8'h00);
  endfunction
  // ====================
  // scramble, encode, interleave
  task t_code;
    logic [7:0] rnd [0:3007];
    logic [14:0] s;
    logic [7:0] b;
    logic [7:0] v;
    logic [7:0] s0;
    logic [7:0] s1;
    int k;
    stall = 1'b1;
    do_reset(1'b0);
    send(8'h47, 1'b1);
    send(din(0, 1), 1'b0);
    @(negedge clk);
    chk(in_ready === 1'b0, "full buffer took a byte");
    idle;
    stall = 1'b0;
    for (int p = 0; p < 16; p++) begin
      if (p > 0) idle;
      while (out_valid) @(negedge clk);
      for (int i = 0; i < 188; i++) begin
        if (p > 0 || i > 1) send(din(p, i), i == 0 && p % 2 == 0);
      end
    end
    idle;
    while (u_sink.n < 3264) @(negedge clk);
    for (int p = 0; p < 16; p++) begin
      for (int i = 0; i < 188; i++) begin
        if (i == 0 && p % 8 == 0) begin
          s = 15'h00A9;
        end else begin
          repeat (8) begin
            b = {b[6:0], s[13] ^ s[14]};
            s = {s[13:0], s[13] ^ s[14]};
          end
        end
        rnd[p * 188 + i] = (i > 0) ? din(p, i) ^ b : ((p % 8 == 0) ? 8'hB8 : 8'h47);
      end
    end
    for (int p = 0; p < 4; p++) begin
      s0 = 8'h00;
      s1 = 8'h00;
      for (int i = 0; i < 204; i++) begin
        k = 204 * p + i;
        v = u_sink.mem[k + 204 * (k % 12)].data;
        if (i < 188) chk(v === rnd[p * 188 + i], "data byte");
        s0 = s0 ^ v;
        s1 = xt(s1) ^ v;
      end
      chk(s0 === 8'h00 && s1 === 8'h00, "parity");
    end
    for (int q = 0; q < 16; q++)
      chk(u_sink.mem[204 * q] === {1'b1, ((q % 8 == 0) ? 8'hB8 : 8'h47)}, "sync");
    $display("t_code done");
  endtask
  // ====================
  // de-interleave after lock on first sync
  task t_deint;
    int k;
    do_reset(1'b1);
    for (int q = 0; q < 2460; q++) send((q == 0) ? 8'h47 : 8'(q * 7 + 1), q == 0);
    idle;
    while (u_sink.n < 2460) @(negedge clk);
    chk(u_sink.mem[1].data === 8'h00, "cleared branch");
    for (int q = 2244; q < 2460; q++) begin
      k = q - 204 * (11 - q % 12);
      chk(u_sink.mem[q].data === ((k == 0) ? 8'h47 : 8'(k * 7 + 1)), "deint");
    end
    $display("t_deint done");
  endtask
  initial begin
    t_code;
    t_deint;
    report_and_stop;
  end
endmodule
